// file: pkg/ats_pkg.sv
// Shared constants, types and helpers of the ASCII telegram link.
// Assumes a single 50 MHz clock on both ends of the link.
package ats_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned BAUD       = 9600;
  localparam int unsigned OVS        = 16;
  localparam int unsigned OVS_CYC    = CLK_HZ / (BAUD * OVS);
  localparam int unsigned RSP_TO_MS  = 50;
  localparam int unsigned RSP_TO_CYC = CLK_HZ / 1000 * RSP_TO_MS;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CHAR_W     = 7;
  localparam logic [3:0]  OVS_MID    = 4'h7;
  localparam logic [3:0]  OVS_LAST   = 4'hF;
  localparam logic [3:0]  BIT_STOP   = 4'h9;
  localparam logic [6:0]  C_STX      = 7'h02;
  localparam logic [6:0]  C_ETX      = 7'h03;
  localparam logic [6:0]  C_EOT      = 7'h04;
  localparam logic [6:0]  C_ENQ      = 7'h05;
  localparam logic [6:0]  C_ACK      = 7'h06;
  localparam logic [6:0]  C_NAK      = 7'h15;
  localparam logic [6:0]  C_EQ       = 7'h3D;
  localparam logic [6:0]  C_ZERO     = 7'h30;
  localparam logic [6:0]  C_NINE     = 7'h39;
  localparam logic [6:0]  C_HEXA     = 7'h41;
  localparam logic [6:0]  C_HEXF     = 7'h46;
  localparam logic [6:0]  C_ADR0     = 7'h40;
  localparam logic [4:0]  ADR_WILD   = 5'h00;
  localparam logic [4:0]  ADR_BCAST  = 5'h1F;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_ADR   = 4'h1,
    S_TYP   = 4'h2,
    S_CODE  = 4'h3,
    S_ENQ   = 4'h4,
    S_EQ    = 4'h5,
    S_VAL   = 4'h6,
    S_ETX   = 4'h7,
    S_BCC   = 4'h8,
    S_ASK   = 4'h9,
    S_REPLY = 4'hA
  } ats_sst_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_SEND = 2'h1,
    M_WAIT = 2'h2
  } ats_mst_e;

  typedef enum logic [1:0] {
    K_DATA = 2'h0,
    K_ACK  = 2'h1,
    K_NAK  = 2'h2,
    K_NONE = 2'h3
  } ats_kind_e;

  function automatic logic ats_par(input logic [6:0] c);
    return ^c;
  endfunction

  function automatic logic ats_is_dig(input logic [6:0] c);
    return (c >= C_ZERO) && (c <= C_NINE);
  endfunction

  function automatic logic [6:0] ats_adr_chr(input logic [4:0] a);
    return C_ADR0 | {2'h0, a};
  endfunction

  function automatic logic [6:0] ats_hex_chr(input logic [3:0] v);
    return (v < 4'hA) ? (C_ZERO | {3'h0, v}) : (C_HEXA + {3'h0, v} - 7'h0A);
  endfunction

  // Bit 4 flags a legal upper-case hex digit
  function automatic logic [4:0] ats_hex_val(input logic [6:0] c);
    if (ats_is_dig(c))
    begin
      return {1'b1, c[3:0]};
    end
    if ((c >= C_HEXA) && (c <= C_HEXF))
    begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction
endpackage

// file: pkg/ats_if.sv
// Two serial wires joining master and converter.
// Assumes idle-high lines; each end drives only its own wire.
`timescale 1ns/100ps
interface ats_if;
  logic m_txd;
  logic s_txd;
  modport dev (input m_txd, output s_txd);
  modport mst (output m_txd, input s_txd);
endinterface

// file: logic/ats_slave.sv
// Converter end of the ASCII telegram link: telegram parser and reply builder.
// Assumes one master, a variable store on the user ports, and the shared serialiser and FIFO.
// How it works
// - Both ends run 9600 bits per second
// - Start, seven code bits, even parity, stop
// - Least significant bit follows the start bit
// - Answer only own station address 1..30
// - Address zero accepted by every converter
// - Address 31 executes writes, never acknowledged
// - Address character is 40 hex plus address
// - Fixed codes for digits and control characters
// - Half duplex, never both transmitting
// - Converter transmits only as an answer
// - Read: EOT, address, five digits, ENQ
// - Read reply: address, STX, code, value, ETX, check
// - Check byte XORs bytes after STX through ETX
// - Every received character parity checked
// - Read and write telegrams both recognised
// - Values carry no decimal point
// - Bad structure or foreign address: silence
// - Any parity error drops the telegram
// - Unknown variable read answers address, NAK
`timescale 1ns/100ps
module ats_slave #(
  parameter int unsigned OVS_CYC = ats_pkg::OVS_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  ats_if.dev               LINK,
  input  wire logic [4:0]  STATION_ADDR,
  output logic             REQ_VALID,
  output logic             REQ_WRITE,
  output logic      [19:0] REQ_CODE,
  output logic      [15:0] REQ_DATA,
  input  wire logic        ANS_VALID,
  input  wire logic        ANS_OK,
  input  wire logic [15:0] ANS_DATA
);
  typedef struct packed {
    ats_pkg::ats_sst_e  st;
    logic [3:0]         n;
    logic               bc;
    logic               wr;
    logic [19:0]        code;
    logic [15:0]        val;
    logic [6:0]         bcc;
    ats_pkg::ats_kind_e rk;
    logic               req;
  } ats_slv_s;
  ats_slv_s   r_ff;
  ats_slv_s   nxt_r;
  logic       rx_v;
  logic [6:0] rx_c;
  logic       rx_pe;
  logic       push;
  logic       f_rdy;
  logic [6:0] pch;
  logic       t_v;
  logic       t_rdy;
  logic [6:0] t_c;
  logic [4:0] hv;
  logic [4:0] a;

  assign REQ_VALID = r_ff.req;
  assign REQ_WRITE = r_ff.wr;
  assign REQ_CODE  = r_ff.code;
  assign REQ_DATA  = r_ff.val;

  ats_uart #(.OVS_CYC(OVS_CYC)) u_uart (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .rxd      (LINK.m_txd),
    .txd      (LINK.s_txd),
    .rx_valid (rx_v),
    .rx_char  (rx_c),
    .rx_perr  (rx_pe),
    .tx_valid (t_v),
    .tx_char  (t_c),
    .tx_ready (t_rdy)
  );

  ats_fifo #(.W(ats_pkg::CHAR_W), .D(ats_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (f_rdy),
    .in_data   (pch),
    .out_valid (t_v),
    .out_ready (t_rdy),
    .out_data  (t_c)
  );

  always_comb
  begin
    nxt_r = r_ff;
    push  = 1'b0;
    hv    = ats_pkg::ats_hex_val(rx_c);
    a     = rx_c[4:0];
    // Reply character for the current index
    pch   = r_ff.bcc;
    if (r_ff.n == 4'h0)
      pch = ats_pkg::ats_adr_chr(STATION_ADDR);
    else if (r_ff.n == 4'h1)
      pch = (r_ff.rk == ats_pkg::K_DATA) ? ats_pkg::C_STX :
            (r_ff.rk == ats_pkg::K_ACK) ? ats_pkg::C_ACK : ats_pkg::C_NAK;
    else if (r_ff.n <= 4'h6)
      pch = ats_pkg::C_ZERO | {3'h0, r_ff.code[19:16]};
    else if (r_ff.n == 4'h7)
      pch = ats_pkg::C_EQ;
    else if (r_ff.n <= 4'hB)
      pch = ats_pkg::ats_hex_chr(r_ff.val[15:12]);
    else if (r_ff.n == 4'hC)
      pch = ats_pkg::C_ETX;
    unique case (r_ff.st)
      ats_pkg::S_ASK:
        if (ANS_VALID)
        begin
          nxt_r.req = 1'b0;
          nxt_r.n   = '0;
          nxt_r.bcc = '0;
          nxt_r.val = ANS_DATA;
          nxt_r.rk  = !ANS_OK ? ats_pkg::K_NAK : r_ff.wr ? ats_pkg::K_ACK : ats_pkg::K_DATA;
          nxt_r.st  = r_ff.bc ? ats_pkg::S_IDLE : ats_pkg::S_REPLY;
        end
      ats_pkg::S_REPLY:
      begin
        push = 1'b1;
        if (f_rdy)
        begin
          nxt_r.n = r_ff.n + 4'h1;
          if ((r_ff.n >= 4'h2) && (r_ff.n <= 4'h6))
            nxt_r.code = {r_ff.code[15:0], 4'h0};
          if ((r_ff.n >= 4'h8) && (r_ff.n <= 4'hB))
            nxt_r.val = {r_ff.val[11:0], 4'h0};
          if ((r_ff.n >= 4'h2) && (r_ff.n <= 4'hC))
            nxt_r.bcc = r_ff.bcc ^ pch;
          if (r_ff.n == ((r_ff.rk == ats_pkg::K_DATA) ? 4'hD : 4'h1))
            nxt_r.st = ats_pkg::S_IDLE;
        end
      end
      default:
        if (rx_v)
        begin
          if (rx_pe)
            nxt_r.st = ats_pkg::S_IDLE;
          else if (rx_c == ats_pkg::C_EOT)
            nxt_r.st = ats_pkg::S_ADR;
          else
          begin
            nxt_r.st = ats_pkg::S_IDLE;
            case (r_ff.st)
              ats_pkg::S_ADR:
                if ((rx_c[6:5] == 2'b10) && ((a == STATION_ADDR) ||
                    (a == ats_pkg::ADR_WILD) || (a == ats_pkg::ADR_BCAST)))
                begin
                  nxt_r.st = ats_pkg::S_TYP;
                  nxt_r.bc = a == ats_pkg::ADR_BCAST;
                end
              ats_pkg::S_TYP:
                if (rx_c == ats_pkg::C_STX)
                begin
                  nxt_r.wr  = 1'b1;
                  nxt_r.n   = '0;
                  nxt_r.bcc = '0;
                  nxt_r.st  = ats_pkg::S_CODE;
                end
                else if (ats_pkg::ats_is_dig(rx_c))
                begin
                  nxt_r.wr   = 1'b0;
                  nxt_r.code = {r_ff.code[15:0], rx_c[3:0]};
                  nxt_r.n    = 4'h1;
                  nxt_r.st   = ats_pkg::S_CODE;
                end
              ats_pkg::S_CODE:
                if (ats_pkg::ats_is_dig(rx_c))
                begin
                  nxt_r.code = {r_ff.code[15:0], rx_c[3:0]};
                  nxt_r.n    = r_ff.n + 4'h1;
                  nxt_r.bcc  = r_ff.bcc ^ rx_c;
                  nxt_r.st   = (r_ff.n != 4'h4) ? ats_pkg::S_CODE :
                               r_ff.wr ? ats_pkg::S_EQ : ats_pkg::S_ENQ;
                end
              ats_pkg::S_ENQ:
                if ((rx_c == ats_pkg::C_ENQ) && !r_ff.bc)
                begin
                  nxt_r.req = 1'b1;
                  nxt_r.st  = ats_pkg::S_ASK;
                end
              ats_pkg::S_EQ:
                if (rx_c == ats_pkg::C_EQ)
                begin
                  nxt_r.bcc = r_ff.bcc ^ rx_c;
                  nxt_r.n   = '0;
                  nxt_r.st  = ats_pkg::S_VAL;
                end
              ats_pkg::S_VAL:
                if (hv[4])
                begin
                  nxt_r.val = {r_ff.val[11:0], hv[3:0]};
                  nxt_r.bcc = r_ff.bcc ^ rx_c;
                  nxt_r.n   = r_ff.n + 4'h1;
                  nxt_r.st  = (r_ff.n == 4'h3) ? ats_pkg::S_ETX : ats_pkg::S_VAL;
                end
              ats_pkg::S_ETX:
                if (rx_c == ats_pkg::C_ETX)
                begin
                  nxt_r.bcc = r_ff.bcc ^ rx_c;
                  nxt_r.st  = ats_pkg::S_BCC;
                end
              ats_pkg::S_BCC:
                if (rx_c == r_ff.bcc)
                begin
                  nxt_r.req = 1'b1;
                  nxt_r.st  = ats_pkg::S_ASK;
                end
                else if (!r_ff.bc)
                begin
                  nxt_r.rk = ats_pkg::K_NAK;
                  nxt_r.n  = '0;
                  nxt_r.st = ats_pkg::S_REPLY;
                end
              default: ;
            endcase
          end
        end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
endmodule

// file: logic/ats_master.sv
// Master end of the ASCII telegram link, with the serialiser that both ends use and the FIFO that only the converter uses.
// Assumes the package is compiled first and one addressed converter answers each telegram.
`timescale 1ns/100ps
module ats_fifo #(
  parameter int unsigned W = ats_pkg::CHAR_W,
  parameter int unsigned D = ats_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } ats_fifo_s;
  ats_fifo_s r_ff;
  ats_fifo_s nxt_r;
  logic      push;
  logic      pop;

  assign in_ready  = r_ff.cnt != (AW+1)'(D);
  assign out_valid = r_ff.cnt != '0;
  assign out_data  = r_ff.mem[r_ff.rp];

  always_comb
  begin
    nxt_r = r_ff;
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    if (push)
    begin
      nxt_r.mem[r_ff.wp] = in_data;
      nxt_r.wp = (r_ff.wp == AW'(D - 1)) ? '0 : r_ff.wp + AW'(1);
    end
    if (pop)
    begin
      nxt_r.rp = (r_ff.rp == AW'(D - 1)) ? '0 : r_ff.rp + AW'(1);
    end
    nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
endmodule

module ats_uart #(
  parameter int unsigned OVS_CYC = ats_pkg::OVS_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic            rx_valid,
  output logic      [6:0] rx_char,
  output logic            rx_perr,
  input  wire logic       tx_valid,
  input  wire logic [6:0] tx_char,
  output logic            tx_ready
);
  typedef struct packed {
    logic [15:0] div;
    logic        tick;
    logic        rbusy;
    logic [3:0]  rt;
    logic [3:0]  rb;
    logic [7:0]  rsh;
    logic        rv;
    logic [6:0]  rc;
    logic        rpe;
    logic        tbusy;
    logic [3:0]  tt;
    logic [3:0]  tb;
    logic [8:0]  tsh;
    logic        txd;
  } ats_uart_s;
  localparam ats_uart_s RST = '{txd: 1'b1, default: '0};
  ats_uart_s r_ff;
  ats_uart_s nxt_r;

  assign txd      = r_ff.txd;
  assign rx_valid = r_ff.rv;
  assign rx_char  = r_ff.rc;
  assign rx_perr  = r_ff.rpe;
  assign tx_ready = !r_ff.tbusy;

  always_comb
  begin
    nxt_r      = r_ff;
    nxt_r.rv   = 1'b0;
    nxt_r.tick = 1'b0;
    if (r_ff.div == 16'(OVS_CYC - 1))
    begin
      nxt_r.div  = '0;
      nxt_r.tick = 1'b1;
    end
    else
      nxt_r.div = r_ff.div + 16'h0001;
    if (r_ff.tick)
    begin
      if (!r_ff.rbusy)
      begin
        if (!rxd)
        begin
          nxt_r.rbusy = 1'b1;
          nxt_r.rt    = '0;
          nxt_r.rb    = '0;
        end
      end
      else
      begin
        nxt_r.rt = r_ff.rt + 4'h1;
        if (r_ff.rt == ats_pkg::OVS_MID)
        begin
          nxt_r.rb = r_ff.rb + 4'h1;
          if (r_ff.rb == 4'h0)
            nxt_r.rbusy = !rxd;
          else if (r_ff.rb == ats_pkg::BIT_STOP)
          begin
            nxt_r.rbusy = 1'b0;
            nxt_r.rv    = 1'b1;
            nxt_r.rc    = r_ff.rsh[6:0];
            nxt_r.rpe   = (^r_ff.rsh) || !rxd;
          end
          else
            nxt_r.rsh = {rxd, r_ff.rsh[7:1]};
        end
      end
      if (r_ff.tbusy)
      begin
        nxt_r.tt = r_ff.tt + 4'h1;
        if (r_ff.tt == ats_pkg::OVS_LAST)
        begin
          nxt_r.tb = r_ff.tb + 4'h1;
          if (r_ff.tb == ats_pkg::BIT_STOP)
          begin
            nxt_r.tbusy = 1'b0;
            nxt_r.txd   = 1'b1;
          end
          else
          begin
            nxt_r.txd = r_ff.tsh[0];
            nxt_r.tsh = {1'b1, r_ff.tsh[8:1]};
          end
        end
      end
    end
    if (tx_valid && !r_ff.tbusy)
    begin
      nxt_r.tbusy = 1'b1;
      nxt_r.tt    = '0;
      nxt_r.tb    = '0;
      nxt_r.txd   = 1'b0;
      nxt_r.tsh   = {1'b1, ats_pkg::ats_par(tx_char), tx_char};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r_ff <= RST;
    else
      r_ff <= nxt_r;
  end
endmodule

module ats_master #(
  parameter int unsigned OVS_CYC    = ats_pkg::OVS_CYC,
  parameter int unsigned RSP_TO_CYC = ats_pkg::RSP_TO_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  ats_if.mst               LINK,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_WRITE,
  input  wire logic [4:0]  CMD_ADDR,
  input  wire logic [19:0] CMD_CODE,
  input  wire logic [15:0] CMD_DATA,
  output logic             CMD_READY,
  output logic             RSP_VALID,
  output ats_pkg::ats_kind_e RSP_STATUS,
  output logic      [15:0] RSP_DATA
);
  typedef struct packed {
    ats_pkg::ats_mst_e  st;
    logic               wr;
    logic [4:0]         adr;
    logic [19:0]        code;
    logic [15:0]        val;
    logic [3:0]         n;
    logic [6:0]         bcc;
    logic [31:0]        to;
    logic               bad;
    logic               rdy;
    logic               rv;
    ats_pkg::ats_kind_e rs;
    logic [15:0]        rd;
  } ats_mst_s;
  ats_mst_s   r_ff;
  ats_mst_s   nxt_r;
  logic       rx_v;
  logic [6:0] rx_c;
  logic       rx_pe;
  logic       t_v;
  logic       t_rdy;
  logic [6:0] ch;
  logic       isd;
  logic       ish;
  logic [4:0] hv;

  assign CMD_READY  = r_ff.rdy;
  assign RSP_VALID  = r_ff.rv;
  assign RSP_STATUS = r_ff.rs;
  assign RSP_DATA   = r_ff.rd;

  ats_uart #(.OVS_CYC(OVS_CYC)) u_uart (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .rxd      (LINK.s_txd),
    .txd      (LINK.m_txd),
    .rx_valid (rx_v),
    .rx_char  (rx_c),
    .rx_perr  (rx_pe),
    .tx_valid (t_v),
    .tx_char  (ch),
    .tx_ready (t_rdy)
  );

  always_comb
  begin
    nxt_r    = r_ff;
    nxt_r.rv = 1'b0;
    t_v      = 1'b0;
    isd      = 1'b0;
    ish      = 1'b0;
    hv       = ats_pkg::ats_hex_val(rx_c);
    // Outgoing character for the current index
    ch       = r_ff.bcc;
    if (r_ff.n == 4'h0)
      ch = ats_pkg::C_EOT;
    else if (r_ff.n == 4'h1)
      ch = ats_pkg::ats_adr_chr(r_ff.adr);
    else if (r_ff.wr && (r_ff.n == 4'h2))
      ch = ats_pkg::C_STX;
    else if (r_ff.n <= (r_ff.wr ? 4'h7 : 4'h6))
    begin
      ch  = ats_pkg::C_ZERO | {3'h0, r_ff.code[19:16]};
      isd = 1'b1;
    end
    else if (!r_ff.wr)
      ch = ats_pkg::C_ENQ;
    else if (r_ff.n == 4'h8)
      ch = ats_pkg::C_EQ;
    else if (r_ff.n <= 4'hC)
    begin
      ch  = ats_pkg::ats_hex_chr(r_ff.val[15:12]);
      ish = 1'b1;
    end
    else if (r_ff.n == 4'hD)
      ch = ats_pkg::C_ETX;
    unique case (r_ff.st)
      ats_pkg::M_IDLE:
      begin
        nxt_r.rdy = 1'b1;
        if (CMD_VALID && r_ff.rdy)
        begin
          nxt_r.rdy  = 1'b0;
          nxt_r.wr   = CMD_WRITE;
          nxt_r.adr  = CMD_ADDR;
          nxt_r.code = CMD_CODE;
          nxt_r.val  = CMD_DATA;
          nxt_r.n    = '0;
          nxt_r.bcc  = '0;
          nxt_r.st   = ats_pkg::M_SEND;
        end
      end
      ats_pkg::M_SEND:
      begin
        t_v = 1'b1;
        if (t_rdy)
        begin
          nxt_r.n = r_ff.n + 4'h1;
          if (isd)
            nxt_r.code = {r_ff.code[15:0], 4'h0};
          if (ish)
            nxt_r.val = {r_ff.val[11:0], 4'h0};
          if ((r_ff.n >= 4'h3) && (r_ff.n <= 4'hD))
            nxt_r.bcc = r_ff.bcc ^ ch;
          if (r_ff.n == (r_ff.wr ? 4'hE : 4'h7))
          begin
            nxt_r.n   = '0;
            nxt_r.to  = '0;
            nxt_r.bad = 1'b0;
            nxt_r.st  = ats_pkg::M_WAIT;
          end
        end
      end
      ats_pkg::M_WAIT:
      begin
        nxt_r.to = r_ff.to + 32'h1;
        if (r_ff.to == (RSP_TO_CYC - 1))
        begin
          nxt_r.rv  = 1'b1;
          nxt_r.rs  = ats_pkg::K_NONE;
          nxt_r.st  = ats_pkg::M_IDLE;
          nxt_r.rdy = 1'b1;
        end
        else if (rx_v)
        begin
          nxt_r.n   = r_ff.n + 4'h1;
          nxt_r.bad = r_ff.bad || rx_pe;
          if ((r_ff.n >= 4'h2) && (r_ff.n <= 4'hC))
            nxt_r.bcc = r_ff.bcc ^ rx_c;
          if (r_ff.n == 4'h1)
          begin
            nxt_r.bcc = '0;
            if ((rx_c == ats_pkg::C_ACK) || (rx_c == ats_pkg::C_NAK))
            begin
              nxt_r.rv  = 1'b1;
              nxt_r.rs  = (r_ff.bad || rx_pe) ? ats_pkg::K_NONE :
                          (rx_c == ats_pkg::C_ACK) ? ats_pkg::K_ACK : ats_pkg::K_NAK;
              nxt_r.st  = ats_pkg::M_IDLE;
              nxt_r.rdy = 1'b1;
            end
            else if (rx_c != ats_pkg::C_STX)
              nxt_r.bad = 1'b1;
          end
          if ((r_ff.n >= 4'h8) && (r_ff.n <= 4'hB))
          begin
            nxt_r.rd  = {r_ff.rd[11:0], hv[3:0]};
            nxt_r.bad = r_ff.bad || rx_pe || !hv[4];
          end
          if (r_ff.n == 4'hD)
          begin
            nxt_r.rv  = 1'b1;
            nxt_r.rs  = (r_ff.bad || rx_pe || (rx_c != r_ff.bcc)) ?
                        ats_pkg::K_NONE : ats_pkg::K_DATA;
            nxt_r.st  = ats_pkg::M_IDLE;
            nxt_r.rdy = 1'b1;
          end
        end
      end
      default:
        nxt_r.st = ats_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
endmodule

// file: tb/ats_link_asserts.sv
// Link checker: converter frame timing, parity and handshake properties.
// Assumes one clock domain and both ends joined on one link interface.
`timescale 1ns/100ps
module ats_link_asserts #(
  parameter int unsigned OVS_CYC = 4
) (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        m_txd,
  input wire logic        s_txd,
  input wire logic        CMD_READY,
  input wire logic        RSP_VALID,
  input wire logic        REQ_VALID,
  input wire logic [19:0] REQ_CODE,
  input wire logic        ANS_VALID
);
  localparam int BT = OVS_CYC * 16;
  localparam int STP = 9 * BT + BT / 2;
  int   cnt_ff;
  logic busy_ff;
  logic par_ff;
  logic mid;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  assign mid = (cnt_ff > BT) && (cnt_ff < STP) && (cnt_ff % BT == BT / 2);
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_ff  <= 0;
      busy_ff <= 1'b0;
      par_ff  <= 1'b0;
    end
    else
    begin
      cnt_ff  <= busy_ff ? cnt_ff + 1 : 1;
      busy_ff <= busy_ff ? (cnt_ff != STP) : !s_txd;
      par_ff  <= busy_ff ? par_ff ^ (s_txd & mid) : 1'b0;
    end
  end
  a_start_bit: assert property (busy_ff && cnt_ff < BT - OVS_CYC |-> !s_txd)
    else $error("start bit too short");
  a_stop_bit: assert property (busy_ff && cnt_ff == STP |-> s_txd)
    else $error("stop bit low");
  a_even_par: assert property (busy_ff && cnt_ff == STP |-> !par_ff)
    else $error("odd parity sent");
  a_half_dup: assert property (m_txd || s_txd)
    else $error("both ends transmitting");
  a_no_unasked: assert property (CMD_READY |-> s_txd)
    else $error("converter sent unasked");
  a_req_hold: assert property (REQ_VALID && !ANS_VALID |=> REQ_VALID && $stable(REQ_CODE))
    else $error("request dropped early");
  a_req_done: assert property (REQ_VALID && ANS_VALID |=> !REQ_VALID)
    else $error("request not released");
  a_rsp_ready: assert property (RSP_VALID |-> ##[0:1] CMD_READY ##1 !RSP_VALID)
    else $error("response handshake wrong");
  c_answer: cover property (REQ_VALID && ANS_VALID);
  c_frame: cover property (busy_ff && cnt_ff == STP);
  c_resp: cover property (RSP_VALID);
endmodule

// file: tb/tb_top.sv
// Testbench: master and converter joined on one link, user sides driven.
// Assumes short bit timing (OVS_CYC 4) and converter station address 2.
`timescale 1ns/100ps
module tb_top;
  localparam int BT = 64;
  typedef struct packed {
    logic               wr;
    logic [4:0]         adr;
    logic [19:0]        code;
    logic [15:0]        dat;
    logic               ok;
    logic [15:0]        ans;
    logic               req;
    ats_pkg::ats_kind_e st;
  } ats_row_s;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cmd_valid = 1'b0;
  logic               ans_valid = 1'b0;
  ats_row_s           cur = '0;
  logic               cmd_ready, rsp_valid, req_valid, req_write;
  logic [19:0]        req_code;
  logic [15:0]        req_data, rsp_data;
  ats_pkg::ats_kind_e rsp_status;
  int                 error_cnt = 0, n_checks = 0, req_cnt = 0, exp_req = 0, cyc = 0;
  ats_row_s           rows [6];
  ats_if link_if ();
  ats_slave #(.OVS_CYC(4)) ats_slave_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
    .LINK(link_if.dev), .STATION_ADDR(5'h02), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_CODE(req_code), .REQ_DATA(req_data),
    .ANS_VALID(ans_valid), .ANS_OK(cur.ok), .ANS_DATA(cur.ans));
  ats_master #(.OVS_CYC(4), .RSP_TO_CYC(10000)) ats_master_inst (.REF_CLK(ref_clk),
    .RST_N(rst_n), .LINK(link_if.mst), .CMD_VALID(cmd_valid), .CMD_WRITE(cur.wr),
    .CMD_ADDR(cur.adr), .CMD_CODE(cur.code), .CMD_DATA(cur.dat), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_STATUS(rsp_status), .RSP_DATA(rsp_data));
  ats_link_asserts #(.OVS_CYC(4)) ats_link_asserts_inst (.REF_CLK(ref_clk),
    .RST_N(rst_n), .m_txd(link_if.m_txd), .s_txd(link_if.s_txd),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .REQ_VALID(req_valid),
    .REQ_CODE(req_code), .ANS_VALID(ans_valid));
  always #10 ref_clk = ~ref_clk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // User side answers each request one cycle after seeing it
  always @(posedge ref_clk)
  begin
    ans_valid <= req_valid && !ans_valid;
    if (req_valid && !ans_valid)
    begin
      req_cnt++;
      check("req_write", req_write, cur.wr);
      check("req_code", req_code, cur.code);
      if (cur.wr) check("req_data", req_data, cur.dat);
    end
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // Samples one character mid-bit, first bit into bit 0
  task automatic grab(input logic sel, input logic [7:0] exp);
    logic [7:0] b;
    b = '0;
    while ((sel ? link_if.s_txd : link_if.m_txd) !== 1'b0) @(posedge ref_clk);
    repeat (BT / 2) @(posedge ref_clk);
    repeat (8)
    begin
      repeat (BT) @(posedge ref_clk);
      b = {(sel ? link_if.s_txd : link_if.m_txd), b[7:1]};
    end
    check(sel ? "reply_first" : "telegram_first", b, exp);
  endtask
  task automatic issue(input ats_row_s r);
    repeat (BT * 2) @(posedge ref_clk);
    cur <= r;
    cmd_valid <= 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  task automatic run_row(input ats_row_s r);
    exp_req += r.req;
    issue(r);
    grab(1'b0, 8'h84);
    if (r.st != ats_pkg::K_NONE) grab(1'b1, 8'h42);
    do @(posedge ref_clk); while (rsp_valid !== 1'b1);
    check("rsp_status", rsp_status, r.st);
    if (r.st == ats_pkg::K_DATA) check("rsp_data", rsp_data, r.ans);
    check("req_count", req_cnt, exp_req);
  endtask
  initial
  begin
    rows[0] = {1'b0, 5'h02, 20'h00123, 16'h0000, 1'b1, 16'h3FA9, 1'b1, ats_pkg::K_DATA};
    rows[1] = {1'b0, 5'h00, 20'h00001, 16'h0000, 1'b1, 16'h0310, 1'b1, ats_pkg::K_DATA};
    rows[2] = {1'b1, 5'h02, 20'h00057, 16'hA5F0, 1'b1, 16'h0000, 1'b1, ats_pkg::K_ACK};
    rows[3] = {1'b0, 5'h02, 20'h00999, 16'h0000, 1'b0, 16'h0000, 1'b1, ats_pkg::K_NAK};
    rows[4] = {1'b1, 5'h1F, 20'h00003, 16'hC001, 1'b1, 16'h0000, 1'b1, ats_pkg::K_NONE};
    rows[5] = {1'b0, 5'h07, 20'h00002, 16'h0000, 1'b1, 16'h0000, 1'b0, ats_pkg::K_NONE};
    repeat (20) @(posedge ref_clk);
    check("idle_m", link_if.m_txd, 1'b1);
    check("idle_s", link_if.s_txd, 1'b1);
    check("ready_rst", cmd_ready, 1'b0);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("ready_up", cmd_ready, 1'b1);
    foreach (rows[i]) run_row(rows[i]);
    // Reset in mid telegram, then a clean telegram must still work
    issue(rows[0]);
    repeat (BT * 3) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("rst_m", link_if.m_txd, 1'b1);
    check("rst_req", req_valid, 1'b0);
    check("rst_ready", cmd_ready, 1'b0);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    run_row(rows[3]);
    complete_run();
  end
endmodule
